// ==== rtl/cat_pkg.sv ====
// constants shared by the channel allocation table and its entry decoder
package cat_pkg;
    localparam int ENTRY_W = 16;
    localparam int NUM_ENTRIES = 128;
    localparam int PORT_ENTRIES = 64;
    localparam int IDX_W = 7;
    localparam int CHAN_W = 6;
    localparam int LABEL_W = 6;
    localparam int TYPE_W = 3;
    localparam int NUM_PORTS = 2;
    localparam int SERIAL_PORT = 0;
    localparam int HOST_PORT = 1;
    localparam logic [IDX_W-1:0] SERIAL_BASE = 7'h00;
    localparam logic [IDX_W-1:0] HOST_BASE = 7'h40;
    localparam int LABEL_LSB = 0;
    localparam int RSVD_LO_BIT = 7;
    localparam int TYPE_LSB = 8;
    localparam int ENABLE_BIT = 11;
    localparam int DIR_BIT = 12;
    localparam int MUTE_BIT = 13;
    localparam int OPT_BIT = 14;
    localparam int RSVD_HI_BIT = 15;
    localparam logic [ENTRY_W-1:0] ENTRY_STORE_MASK = 16'h7f3f;
    localparam logic [ENTRY_W-1:0] ENTRY_RESET = 16'h0000;
    localparam logic [TYPE_W-1:0] TYPE_SYNC = 3'h0;
    localparam logic [TYPE_W-1:0] TYPE_CTRL = 3'h1;
    localparam logic [TYPE_W-1:0] TYPE_ASYNC = 3'h2;
    localparam logic [TYPE_W-1:0] TYPE_ISO = 3'h3;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h200;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h204;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int STAT_SERIAL_ACTIVE_BIT = 0;
    localparam int STAT_HOST_ACTIVE_BIT = 1;
    localparam int STAT_SERIAL_LABEL_LSB = 8;
    localparam int STAT_HOST_LABEL_LSB = 16;
endpackage

// ==== rtl/cat_lookup_if.sv ====
// one table entry and its decoded channel fields
`timescale 1ns/1ps
interface cat_lookup_if (
    input wire logic clk
);
    import cat_pkg::*;
    logic [ENTRY_W-1:0] entry;
    logic routed;
    logic enable;
    logic direction_read;
    logic mute_enable;
    logic iso_option_flag;
    logic sync_option_flag;
    logic [LABEL_W-1:0] connection_label;
    logic [TYPE_W-1:0] channel_type;
    modport table_side (output entry, input routed, enable, direction_read, mute_enable,
        iso_option_flag, sync_option_flag, connection_label, channel_type);
    modport decoder (input clk, input entry, output routed, enable, direction_read, mute_enable,
        iso_option_flag, sync_option_flag, connection_label, channel_type);
endinterface

// ==== rtl/cat_entry_decode.sv ====
// decodes one channel allocation entry into its per-type fields
`timescale 1ns/1ps
module cat_entry_decode (
    cat_lookup_if.decoder dec
);
    import cat_pkg::*;

    logic [TYPE_W-1:0] ctype;
    logic known;

    always_comb begin
        ctype = dec.entry[TYPE_LSB +: TYPE_W];
        known = (ctype == TYPE_SYNC) || (ctype == TYPE_CTRL) ||
                (ctype == TYPE_ASYNC) || (ctype == TYPE_ISO);
        dec.channel_type = ctype;
        dec.routed = known;
        dec.connection_label = known ? dec.entry[LABEL_LSB +: LABEL_W] : '0;
        dec.enable = known && dec.entry[ENABLE_BIT];
        dec.direction_read = known && dec.entry[DIR_BIT];
        // bit 13 means nothing in isochronous entries
        dec.mute_enable = known && (ctype != TYPE_ISO) && dec.entry[MUTE_BIT];
        dec.iso_option_flag = (ctype == TYPE_ISO) && dec.entry[OPT_BIT];
        dec.sync_option_flag = (ctype == TYPE_SYNC) && dec.entry[OPT_BIT];
    end

    property p_reserved_type_unrouted;
        @(posedge dec.clk)
        dec.entry[TYPE_LSB + 2] |-> (!dec.routed && !dec.enable && dec.connection_label == '0);
    endproperty
    a_reserved_type_unrouted: assert property (p_reserved_type_unrouted)
        else $error("reserved channel type decoded as routed");
endmodule

// ==== rtl/channel_allocation_table.sv ====
// channel allocation table: 128 entries behind apb with two channel lookup ports
// Function
// - each entry is found by a fixed physical index of its channel, not software.
// - every entry carries a 6-bit connection label pointing into the descriptor table.
// - indices 0 to 63 belong to the serial media-bus port.
// - indices 64 to 127 belong to the host bus port.
// - label bits 5:0, bit 7 reserved, type 10:8, enable 11, direction 12.
// - type 0 sync, 1 control, 2 async, 3 isochronous, 4 to 7 reserved.
// - enable bit 1 makes the channel active, 0 disables it.
// - direction bit 1 means read channel, 0 means write channel.
// - bit 13 is mute enable except in isochronous entries.
// - bit 14 is iso option or sync option by type; bit 15 reserved.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
module channel_allocation_table (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cat_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_req,
    input wire logic [cat_pkg::CHAN_W-1:0] serial_chan,
    input wire logic host_req,
    input wire logic [cat_pkg::CHAN_W-1:0] host_chan,
    output logic serial_valid,
    output logic serial_active,
    output logic [cat_pkg::LABEL_W-1:0] serial_label,
    output logic [cat_pkg::TYPE_W-1:0] serial_type,
    output logic serial_read,
    output logic serial_mute,
    output logic serial_iso_opt,
    output logic serial_sync_opt,
    output logic host_valid,
    output logic host_active,
    output logic [cat_pkg::LABEL_W-1:0] host_label,
    output logic [cat_pkg::TYPE_W-1:0] host_type,
    output logic host_read,
    output logic host_mute,
    output logic host_iso_opt,
    output logic host_sync_opt
);
    import cat_pkg::*;

    logic [ENTRY_W-1:0] tbl_r [NUM_ENTRIES];
    logic [ENTRY_W-1:0] tbl_nxt [NUM_ENTRIES];
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;

    logic setup_phase;
    logic wr_commit;
    logic tbl_hit;
    logic addr_ok;
    logic [IDX_W-1:0] bus_idx;
    logic [ENTRY_W-1:0] wr_entry;
    logic [31:0] status_w;

    // lookup side, one slot per peripheral port
    logic [NUM_PORTS-1:0] lk_req;
    logic [CHAN_W-1:0] lk_chan [NUM_PORTS];
    logic [IDX_W-1:0] lk_idx [NUM_PORTS];
    logic [NUM_PORTS-1:0] valid_r, valid_nxt;
    logic [NUM_PORTS-1:0] active_r, active_nxt;
    logic [NUM_PORTS-1:0] read_r, read_nxt;
    logic [NUM_PORTS-1:0] mute_r, mute_nxt;
    logic [NUM_PORTS-1:0] iso_r, iso_nxt;
    logic [NUM_PORTS-1:0] sync_r, sync_nxt;
    logic [LABEL_W-1:0] label_r [NUM_PORTS];
    logic [LABEL_W-1:0] label_nxt [NUM_PORTS];
    logic [TYPE_W-1:0] type_r [NUM_PORTS];
    logic [TYPE_W-1:0] type_nxt [NUM_PORTS];
    logic [ENTRY_W-1:0] seen_r [NUM_PORTS];
    logic [ENTRY_W-1:0] lk_entry [NUM_PORTS];

    assign lk_req = {host_req, serial_req};
    assign lk_chan[SERIAL_PORT] = serial_chan;
    assign lk_chan[HOST_PORT] = host_chan;
    // the port fixes the top index bit, the channel number the lower six: software cannot remap
    assign lk_idx[SERIAL_PORT] = SERIAL_BASE | {1'b0, serial_chan};
    assign lk_idx[HOST_PORT] = HOST_BASE | {1'b0, host_chan};

    // apb slave: zero wait states, pready raised for the first access cycle
    always_comb begin
        setup_phase = psel && !penable;
        tbl_hit = (paddr[ADDR_W-1:9] == '0);
        bus_idx = paddr[8:2];
        addr_ok = (paddr[1:0] == 2'b00) && (tbl_hit || paddr == CTRL_ADDR || paddr == STATUS_ADDR);
        wr_commit = psel && penable && pready_r && pwrite && !pslverr_r;
        status_w = '0;
        status_w[STAT_SERIAL_ACTIVE_BIT] = active_r[SERIAL_PORT];
        status_w[STAT_HOST_ACTIVE_BIT] = active_r[HOST_PORT];
        status_w[STAT_SERIAL_LABEL_LSB +: LABEL_W] = label_r[SERIAL_PORT];
        status_w[STAT_HOST_LABEL_LSB +: LABEL_W] = label_r[HOST_PORT];
        pready_nxt = setup_phase;
        pslverr_nxt = setup_phase && !addr_ok;
        prdata_nxt = prdata_r;
        if (setup_phase) begin
            prdata_nxt = '0;
            if (!addr_ok) begin
                prdata_nxt = '0;
            end else if (tbl_hit) begin
                prdata_nxt = {16'h0000, tbl_r[bus_idx]};
            end else if (paddr == CTRL_ADDR) begin
                prdata_nxt = ctrl_r;
            end else begin
                prdata_nxt = status_w;
            end
        end
        ctrl_nxt = ctrl_r;
        if (wr_commit && paddr == CTRL_ADDR && pstrb[0]) begin
            ctrl_nxt = {31'h0, pwdata[CTRL_ENABLE_BIT]};
        end
        // reserved bits 7 and 15 are never stored, so they always read zero
        wr_entry = pwdata[ENTRY_W-1:0] & ENTRY_STORE_MASK;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RESET;
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // one flop word per entry, byte lanes 0 and 1 carry the entry
    genvar e;
    generate
        for (e = 0; e < NUM_ENTRIES; e++) begin : g_entry
            always_comb begin
                tbl_nxt[e] = tbl_r[e];
                if (wr_commit && tbl_hit && bus_idx == IDX_W'(e)) begin
                    if (pstrb[0]) begin
                        tbl_nxt[e][7:0] = wr_entry[7:0];
                    end
                    if (pstrb[1]) begin
                        tbl_nxt[e][15:8] = wr_entry[15:8];
                    end
                end
            end
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    tbl_r[e] <= ENTRY_RESET;
                end else begin
                    tbl_r[e] <= tbl_nxt[e];
                end
            end
        end
    endgenerate

    // lookups read the table as it stood before a write in the same cycle
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            cat_lookup_if lk (.clk(clk));
            assign lk_entry[p] = tbl_r[lk_idx[p]];
            assign lk.entry = lk_entry[p];
            cat_entry_decode u_dec (
                .dec(lk.decoder)
            );
            always_comb begin
                valid_nxt[p] = lk_req[p];
                active_nxt[p] = active_r[p];
                read_nxt[p] = read_r[p];
                mute_nxt[p] = mute_r[p];
                iso_nxt[p] = iso_r[p];
                sync_nxt[p] = sync_r[p];
                label_nxt[p] = label_r[p];
                type_nxt[p] = type_r[p];
                if (lk_req[p]) begin
                    // a reserved type or a cleared global enable leaves the channel idle
                    active_nxt[p] = lk.routed && lk.enable && ctrl_r[CTRL_ENABLE_BIT];
                    read_nxt[p] = lk.direction_read;
                    mute_nxt[p] = lk.mute_enable;
                    iso_nxt[p] = lk.iso_option_flag;
                    sync_nxt[p] = lk.sync_option_flag;
                    label_nxt[p] = lk.connection_label;
                    type_nxt[p] = lk.channel_type;
                end
            end
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    valid_r[p] <= 1'b0;
                    active_r[p] <= 1'b0;
                    read_r[p] <= 1'b0;
                    mute_r[p] <= 1'b0;
                    iso_r[p] <= 1'b0;
                    sync_r[p] <= 1'b0;
                    label_r[p] <= '0;
                    type_r[p] <= '0;
                    seen_r[p] <= '0;
                end else begin
                    valid_r[p] <= valid_nxt[p];
                    active_r[p] <= active_nxt[p];
                    read_r[p] <= read_nxt[p];
                    mute_r[p] <= mute_nxt[p];
                    iso_r[p] <= iso_nxt[p];
                    sync_r[p] <= sync_nxt[p];
                    label_r[p] <= label_nxt[p];
                    type_r[p] <= type_nxt[p];
                    seen_r[p] <= lk_req[p] ? lk_entry[p] : seen_r[p];
                end
            end

            property p_entry_by_index;
                @(posedge clk) disable iff (!rst_n)
                lk_req[p] |=> valid_r[p] && seen_r[p] == tbl_r[$past(lk_idx[p])];
            endproperty
            a_entry_by_index: assert property (p_entry_by_index)
                else $error("lookup did not return the entry at its fixed index");

            property p_label_field;
                @(posedge clk) disable iff (!rst_n)
                valid_r[p] && !seen_r[p][TYPE_LSB + 2] |-> label_r[p] == seen_r[p][5:0];
            endproperty
            a_label_field: assert property (p_label_field)
                else $error("connection label not taken from bits 5:0");

            property p_type_field;
                @(posedge clk) disable iff (!rst_n)
                valid_r[p] |-> type_r[p] == seen_r[p][10:8];
            endproperty
            a_type_field: assert property (p_type_field)
                else $error("channel type not taken from bits 10:8");

            property p_disabled_idle;
                @(posedge clk) disable iff (!rst_n)
                valid_r[p] && !seen_r[p][ENABLE_BIT] |-> !active_r[p];
            endproperty
            a_disabled_idle: assert property (p_disabled_idle)
                else $error("disabled channel reported active");

            property p_reserved_idle;
                @(posedge clk) disable iff (!rst_n)
                valid_r[p] && seen_r[p][TYPE_LSB + 2] |-> !active_r[p] && label_r[p] == '0;
            endproperty
            a_reserved_idle: assert property (p_reserved_idle)
                else $error("reserved channel type used for routing");

            property p_direction;
                @(posedge clk) disable iff (!rst_n)
                valid_r[p] && !seen_r[p][TYPE_LSB + 2] |-> read_r[p] == seen_r[p][DIR_BIT];
            endproperty
            a_direction: assert property (p_direction)
                else $error("direction does not follow bit 12");

            property p_iso_no_mute;
                @(posedge clk) disable iff (!rst_n)
                valid_r[p] && type_r[p] == TYPE_ISO |-> !mute_r[p] && !sync_r[p];
            endproperty
            a_iso_no_mute: assert property (p_iso_no_mute)
                else $error("isochronous entry shows mute or sync option");

            property p_sync_opt;
                @(posedge clk) disable iff (!rst_n)
                valid_r[p] && type_r[p] != TYPE_SYNC |-> !sync_r[p];
            endproperty
            a_sync_opt: assert property (p_sync_opt)
                else $error("sync option flag outside a synchronous entry");
        end
    endgenerate

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access_done;
        psel && penable && pready;
    endsequence
    property p_apb_answer;
        @(posedge clk) disable iff (!rst_n)
        s_setup ##1 penable |-> s_access_done;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("apb access not answered in its first cycle");

    // index rebuilt from the pin: host channels must land in the upper half
    property p_host_half;
        @(posedge clk) disable iff (!rst_n)
        host_req |=> host_valid && seen_r[HOST_PORT] == $past(tbl_r[{1'b1, host_chan}]);
    endproperty
    a_host_half: assert property (p_host_half)
        else $error("port looked up outside its half of the table");

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign serial_valid = valid_r[SERIAL_PORT];
    assign serial_active = active_r[SERIAL_PORT];
    assign serial_label = label_r[SERIAL_PORT];
    assign serial_type = type_r[SERIAL_PORT];
    assign serial_read = read_r[SERIAL_PORT];
    assign serial_mute = mute_r[SERIAL_PORT];
    assign serial_iso_opt = iso_r[SERIAL_PORT];
    assign serial_sync_opt = sync_r[SERIAL_PORT];
    assign host_valid = valid_r[HOST_PORT];
    assign host_active = active_r[HOST_PORT];
    assign host_label = label_r[HOST_PORT];
    assign host_type = type_r[HOST_PORT];
    assign host_read = read_r[HOST_PORT];
    assign host_mute = mute_r[HOST_PORT];
    assign host_iso_opt = iso_r[HOST_PORT];
    assign host_sync_opt = sync_r[HOST_PORT];
endmodule

// ==== verification/cat_port_model.sv ====
// channel port requester that looks table entries up by channel number
`timescale 1ns/1ps
module cat_port_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic want,
    input wire logic [cat_pkg::CHAN_W-1:0] want_chan,
    output logic req,
    output logic [cat_pkg::CHAN_W-1:0] chan,
    output logic asked,
    output logic [cat_pkg::CHAN_W-1:0] asked_chan
);
    import cat_pkg::*;
    always @(posedge clk) begin
        if (!rst_n) begin
            req <= 1'b0;
            chan <= '0;
        end else if (want) begin
            req <= 1'b1;
            chan <= want_chan;
        end else if (run) begin
            req <= 1'($urandom_range(1));
            chan <= CHAN_W'($urandom);
        end else begin
            req <= 1'b0;
            // idle lines wander so a stale channel never looks like a request
            chan <= ~chan;
        end
        asked <= rst_n && req;
        asked_chan <= chan;
    end
endmodule

// ==== verification/test_channel_allocation_table.sv ====
// self-checking bench for the channel allocation table
`timescale 1ns/1ps
module test_channel_allocation_table;
    import cat_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, serial_req, host_req, s_asked, h_asked;
    logic [CHAN_W-1:0] serial_chan, host_chan, s_asked_chan, h_asked_chan;
    logic run = 1'b0, s_want = 1'b0, h_want = 1'b0;
    logic [CHAN_W-1:0] s_wchan = '0, h_wchan = '0;
    logic serial_valid, serial_active, serial_read, serial_mute, serial_iso_opt;
    logic serial_sync_opt, host_valid, host_active, host_read, host_mute;
    logic host_iso_opt, host_sync_opt;
    logic [LABEL_W-1:0] serial_label, host_label;
    logic [TYPE_W-1:0] serial_type, host_type;
    logic [13:0] s_got, h_got;
    logic [15:0] shadow [NUM_ENTRIES];
    logic en_r = 1'b1;
    logic [3:0] strb_r = 4'hf;
    int err_count = 0;
    int check_count = 0;
    assign s_got = {serial_active, serial_read, serial_mute, serial_iso_opt, serial_sync_opt,
        serial_type, serial_label};
    assign h_got = {host_active, host_read, host_mute, host_iso_opt, host_sync_opt,
        host_type, host_label};
    always #50 clk = ~clk;
    channel_allocation_table dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_req(serial_req),
        .serial_chan(serial_chan), .host_req(host_req), .host_chan(host_chan),
        .serial_valid(serial_valid), .serial_active(serial_active),
        .serial_label(serial_label), .serial_type(serial_type), .serial_read(serial_read),
        .serial_mute(serial_mute), .serial_iso_opt(serial_iso_opt),
        .serial_sync_opt(serial_sync_opt), .host_valid(host_valid),
        .host_active(host_active), .host_label(host_label), .host_type(host_type),
        .host_read(host_read), .host_mute(host_mute), .host_iso_opt(host_iso_opt),
        .host_sync_opt(host_sync_opt));
    cat_port_model s_mdl (.clk(clk), .rst_n(rst_n), .run(run), .want(s_want),
        .want_chan(s_wchan), .req(serial_req), .chan(serial_chan), .asked(s_asked),
        .asked_chan(s_asked_chan));
    cat_port_model h_mdl (.clk(clk), .rst_n(rst_n), .run(run), .want(h_want),
        .want_chan(h_wchan), .req(host_req), .chan(host_chan), .asked(h_asked),
        .asked_chan(h_asked_chan));
    // software side zeroes every bit that is reserved for the entry's type
    function automatic logic [15:0] legal(input logic [15:0] d);
        logic [15:0] m;
        m = 16'h1f3f;
        if (d[10:8] == TYPE_SYNC) m = 16'h7f3f;
        else if (d[10:8] == TYPE_ISO) m = 16'h5f3f;
        else if (d[10:8] <= TYPE_ASYNC) m = 16'h3f3f;
        return d & m;
    endfunction
    function automatic logic [13:0] exp_at(input logic [IDX_W-1:0] i);
        logic [15:0] e;
        logic [2:0] t;
        logic k;
        e = shadow[i];
        t = e[10:8];
        k = (t <= TYPE_ISO);
        return {k & e[11] & en_r, k & e[12], (t <= TYPE_ASYNC) & e[13],
            (t == TYPE_ISO) & e[14], (t == TYPE_SYNC) & e[14], t, k ? e[5:0] : 6'h00};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= strb_r;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) err_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr_entry(input logic [IDX_W-1:0] i, input logic [15:0] d);
        logic [31:0] rd;
        logic err;
        shadow[i] = legal(d);
        apb(1'b1, {3'b000, i, 2'b00}, {16'h0, shadow[i]}, rd, err);
        chk({31'h0, err}, 32'h0);
    endtask
    task automatic rd_entry(input logic [IDX_W-1:0] i);
        logic [31:0] rd;
        logic err;
        apb(1'b0, {3'b000, i, 2'b00}, 32'h0, rd, err);
        chk(rd, {16'h0, shadow[i]});
        chk({31'h0, err}, 32'h0);
    endtask
    task automatic lookup(input logic [CHAN_W-1:0] sc, input logic [CHAN_W-1:0] hc);
        s_want <= 1'b1;
        h_want <= 1'b1;
        s_wchan <= sc;
        h_wchan <= hc;
        @(posedge clk);
        s_want <= 1'b0;
        h_want <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic summarize;
        $display("checks=%0d mismatches=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(negedge clk) begin
        if (rst_n) begin
            chk({31'h0, serial_valid}, {31'h0, s_asked});
            chk({31'h0, host_valid}, {31'h0, h_asked});
            if (s_asked) chk({18'h0, s_got}, {18'h0, exp_at({1'b0, s_asked_chan})});
            if (h_asked) chk({18'h0, h_got}, {18'h0, exp_at({1'b1, h_asked_chan})});
        end
    end
    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        summarize();
    end
    initial begin
        logic [31:0] rd;
        logic err;
        logic [15:0] d;
        logic [13:0] es, eh;
        void'($urandom(6112));
        for (int i = 0; i < NUM_ENTRIES; i++) shadow[i] = ENTRY_RESET;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd_entry(7'd0);
        rd_entry(7'd127);
        apb(1'b0, CTRL_ADDR, 32'h0, rd, err);
        chk(rd, CTRL_RESET);
        $display("test reset done");
        for (int t = 0; t < 8; t++) begin
            d = 16'h6800 | (16'(t) << 8) | (16'(t & 1) << 12) | 16'(t + 5);
            wr_entry(7'(t), d);
            wr_entry(7'(64 + t), d ^ 16'h0800);
            lookup(6'(t), 6'(t));
        end
        $display("test types done");
        wr_entry(7'd63, 16'h1b2a);
        wr_entry(7'd64, 16'h0b2a);
        lookup(6'd63, 6'd0);
        chk({26'h0, serial_label}, {26'h0, host_label});
        es = exp_at(7'd63);
        eh = exp_at(7'd64);
        apb(1'b0, STATUS_ADDR, 32'h0, rd, err);
        chk(rd, {10'h0, eh[5:0], 2'h0, es[5:0], 6'h0, eh[13], es[13]});
        apb(1'b1, CTRL_ADDR, 32'h0, rd, err);
        en_r = 1'b0;
        lookup(6'd63, 6'd0);
        apb(1'b1, CTRL_ADDR, 32'h1, rd, err);
        en_r = 1'b1;
        $display("test ports done");
        apb(1'b0, 12'h208, 32'h0, rd, err);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, 12'h00a, 32'h0000_ffff, rd, err);
        chk({31'h0, err}, 32'h1);
        rd_entry(7'd2);
        // lane 0 only: the upper byte of the entry must survive
        strb_r = 4'h1;
        apb(1'b1, 12'h008, 32'h0000_ff15, rd, err);
        strb_r = 4'hf;
        shadow[2][7:0] = 8'h15;
        rd_entry(7'd2);
        $display("test errors done");
        repeat (60) wr_entry(7'($urandom_range(127)), 16'($urandom));
        // lookups only run while no write is in flight, so the shadow stays exact
        run <= 1'b1;
        repeat (300) @(posedge clk);
        run <= 1'b0;
        repeat (3) @(posedge clk);
        for (int i = 0; i < NUM_ENTRIES; i++) rd_entry(7'(i));
        $display("test random done");
        summarize();
    end
endmodule
